// File: fmr_cfg.svh
// constants for the fault monitor and response unit
`ifndef FMR_CFG_SVH
`define FMR_CFG_SVH
`define FMR_RAM_AW 6
`define FMR_RAM_DW 8
`define FMR_SP_W 16
`define FMR_WDG_W 16
`define FMR_LFSR_SEED 6'h2d
`define FMR_LFSR_TAP 6'h30
`define FMR_CAUSE_NONE 4'h0
`define FMR_CAUSE_SENSOR 4'h1
`define FMR_CAUSE_PARITY_RD 4'h2
`define FMR_CAUSE_PARITY_SCAN 4'h3
`define FMR_CAUSE_WATCHDOG 4'h4
`define FMR_CAUSE_POWERON 4'h8
`define FMR_EXC_NONE 4'h0
`define FMR_EXC_SENSOR 4'h1
`define FMR_EXC_STACK 4'h2
`define FMR_EXC_ECC 4'h3
`define FMR_LVL_USER 2'h0
`define FMR_LVL_SYS 2'h1
`define FMR_LVL_SUPER 2'h2
`define FMR_NLVL 3
`endif

// File: fmr_pkg.sv
// types of the fault monitor and response unit
`include "fmr_cfg.svh"
package fmr_pkg;
	typedef logic [3:0] fmr_cause_t;
	typedef enum logic [1:0] {
		FMR_RUN = 2'h0,
		FMR_RESET = 2'h1,
		FMR_HOLD = 2'h3
	} fmr_state_e;
endpackage

// File: fmr_ram.sv
// ram with parity bits stored beside each word, registered read data
`timescale 1ns/1ps
`include "fmr_cfg.svh"
module fmr_ram #(
	parameter int AW = `FMR_RAM_AW,
	parameter int DW = `FMR_RAM_DW
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW:0] wdata,
	output logic [DW:0] rdata
);
	logic [DW:0] mem [0:(1<<AW)-1];
	logic [DW:0] next_rdata;

	// write-through not needed; read is one cycle late
	always_comb begin
		next_rdata = mem[addr];
	end

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= next_rdata;
	end
endmodule

// File: fmr_stack_check.sv
// limit checker for one privilege level's stack pointer
`timescale 1ns/1ps
`include "fmr_cfg.svh"
module fmr_stack_check #(
	parameter int W = `FMR_SP_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sp_we,
	input wire logic [W-1:0] sp_wdata,
	input wire logic [W-1:0] lim_lo,
	input wire logic [W-1:0] lim_hi,
	output logic [W-1:0] sp,
	output logic out_of_range
);
	logic [W-1:0] next_sp;
	logic next_oor;

	// pointer copy and its bound comparison live together
	always_comb begin
		next_sp = sp_we ? sp_wdata : sp;
		next_oor = (next_sp < lim_lo) || (next_sp > lim_hi);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sp <= '0;
			out_of_range <= 1'b0;
		end else begin
			sp <= next_sp;
			out_of_range <= next_oor;
		end
	end
endmodule

// File: fmr_top.sv
// fault monitor and response unit: sensors, ram parity, stack limits, eeprom faults
`timescale 1ns/1ps
`include "fmr_cfg.svh"
// How it works
// - out-of-range sensor forces reset or exception
// - parity stored per ram word, checked on read
// - background scan, random order, idle cycles only
// - any parity error forces security reset
// - security reset clears the exception flag and exception cause; other state keeps its value
// - reset cause readable after reset
// - exception cause recorded, readable
// - software cannot disable or mask sensors
// - three stack pointer copies with checks
// - stack pointer outside limits raises exception
// - eeprom high voltage sampled, latched per write
// - high voltage failure raises no event
// - inverse ecc option raises exception on error
// - software enables eeprom double read
// - software enabled configurable program watchdog
module fmr_top
	import fmr_pkg::*;
#(
	parameter int AW = `FMR_RAM_AW,
	parameter int DW = `FMR_RAM_DW,
	parameter int SPW = `FMR_SP_W,
	parameter int WDW = `FMR_WDG_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] sensor_alarm,
	input wire logic [3:0] sensor_reset_sel,
	input wire logic ram_req,
	input wire logic ram_we,
	input wire logic [AW-1:0] ram_addr,
	input wire logic [DW-1:0] ram_wdata,
	output logic [DW-1:0] ram_rdata,
	output logic ram_rvalid,
	input wire logic [1:0] priv_level,
	input wire logic [`FMR_NLVL-1:0] sp_we,
	input wire logic [SPW-1:0] sp_wdata,
	input wire logic [`FMR_NLVL*SPW-1:0] sp_lim_lo,
	input wire logic [`FMR_NLVL*SPW-1:0] sp_lim_hi,
	output logic [SPW-1:0] sp_active,
	input wire logic ee_write_active,
	input wire logic ee_hv_ok,
	output logic ee_hv_fail,
	input wire logic ee_hv_clear,
	input wire logic ee_ecc_err,
	input wire logic inverse_ecc_en,
	input wire logic double_read_set,
	input wire logic double_read_clr,
	output logic ee_double_read_en,
	input wire logic wdg_enable,
	input wire logic [WDW-1:0] wdg_reload,
	input wire logic wdg_kick,
	output logic security_reset,
	output logic [3:0] reset_cause,
	output logic exception,
	output logic [3:0] exc_cause,
	input wire logic exc_ack
);
	// scan generator taps are fixed for the documented address width
	if (AW != `FMR_RAM_AW || DW < 1 || SPW < 2 || WDW < 2) begin : g_bad_param
		$error("fmr_top: unsupported parameter values");
	end

	// sensor and hv pins come from outside, two flops first
	logic [3:0] alarm_s1, alarm_s2;
	logic hv_s1, hv_s2, wr_s1, wr_s2, ecc_s1, ecc_s2;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_s1 <= '0;
			alarm_s2 <= '0;
			hv_s1 <= 1'b0;
			hv_s2 <= 1'b0;
			wr_s1 <= 1'b0;
			wr_s2 <= 1'b0;
			ecc_s1 <= 1'b0;
			ecc_s2 <= 1'b0;
		end else begin
			alarm_s1 <= sensor_alarm;
			alarm_s2 <= alarm_s1;
			hv_s1 <= ee_hv_ok;
			hv_s2 <= hv_s1;
			wr_s1 <= ee_write_active;
			wr_s2 <= wr_s1;
			ecc_s1 <= ee_ecc_err;
			ecc_s2 <= ecc_s1;
		end
	end

	function automatic logic parity_of(input logic [DW-1:0] d);
		parity_of = ^d;
	endfunction

	// ram port arbitration: software always wins the port
	logic [AW-1:0] lfsr, next_lfsr;
	logic [AW-1:0] mem_addr;
	logic mem_we;
	logic [DW:0] mem_rdata;
	logic rd_pend, scan_pend, next_rd_pend, next_scan_pend;
	logic sw_prev, next_sw_prev;
	always_comb begin
		mem_we = ram_req && ram_we;
		mem_addr = ram_req ? ram_addr : lfsr;
		next_rd_pend = ram_req && !ram_we;
		next_scan_pend = !ram_req;
		next_sw_prev = ram_req;
		next_lfsr = lfsr;
		// advance during idle cycles, jump once after a software access
		if (!ram_req) begin
			// zero state spliced in, so address zero is scanned too
			next_lfsr = {lfsr[AW-2:0], (^(lfsr & `FMR_LFSR_TAP)) ^ (lfsr[AW-2:0] == '0)};
			if (sw_prev) begin
				next_lfsr = lfsr ^ {{(AW-1){1'b0}}, 1'b1} ^ ram_addr;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lfsr <= `FMR_LFSR_SEED;
			rd_pend <= 1'b0;
			scan_pend <= 1'b0;
			sw_prev <= 1'b0;
		end else begin
			lfsr <= next_lfsr;
			rd_pend <= next_rd_pend;
			scan_pend <= next_scan_pend;
			sw_prev <= next_sw_prev;
		end
	end

	fmr_ram #(
		.AW(AW),
		.DW(DW)
	) u_ram (
		.clk(clk),
		.we(mem_we),
		.addr(mem_addr),
		.wdata({parity_of(ram_wdata), ram_wdata}),
		.rdata(mem_rdata)
	);

	// parity check on both the software read and the scan read
	logic par_bad, par_rd_err, par_scan_err;
	always_comb begin
		par_bad = parity_of(mem_rdata[DW-1:0]) != mem_rdata[DW];
		par_rd_err = rd_pend && par_bad;
		par_scan_err = scan_pend && par_bad;
		ram_rdata = mem_rdata[DW-1:0];
		ram_rvalid = rd_pend;
	end

	// three stack pointer copies, one per privilege level
	logic [`FMR_NLVL*SPW-1:0] sp_all;
	logic [`FMR_NLVL-1:0] sp_oor;
	genvar g;
	generate
		for (g = 0; g < `FMR_NLVL; g++) begin : g_sp
			fmr_stack_check #(
				.W(SPW)
			) u_sp (
				.clk(clk),
				.rst_n(rst_n),
				.sp_we(sp_we[g]),
				.sp_wdata(sp_wdata),
				.lim_lo(sp_lim_lo[g*SPW +: SPW]),
				.lim_hi(sp_lim_hi[g*SPW +: SPW]),
				.sp(sp_all[g*SPW +: SPW]),
				.out_of_range(sp_oor[g])
			);
		end
	endgenerate

	logic [1:0] lvl;
	logic stack_fault;
	always_comb begin
		lvl = (priv_level > `FMR_LVL_SUPER) ? `FMR_LVL_SUPER : priv_level;
		sp_active = sp_all[lvl*SPW +: SPW];
		stack_fault = sp_oor[lvl];
	end

	// eeprom hv sensor latch, double read flag, watchdog
	logic hv_fail_q, next_hv_fail;
	logic dr_en, next_dr_en;
	logic [WDW-1:0] wdg_cnt, next_wdg_cnt;
	logic wdg_fire;
	always_comb begin
		next_hv_fail = hv_fail_q;
		if (ee_hv_clear) begin
			next_hv_fail = 1'b0;
		end
		// sample during every write; set wins over clear
		if (wr_s2 && !hv_s2) begin
			next_hv_fail = 1'b1;
		end
		next_dr_en = dr_en;
		if (double_read_clr) begin
			next_dr_en = 1'b0;
		end
		if (double_read_set) begin
			next_dr_en = 1'b1;
		end
		wdg_fire = 1'b0;
		next_wdg_cnt = wdg_reload;
		// count down while enabled, kick reloads
		if (wdg_enable && !wdg_kick) begin
			if (wdg_cnt == '0) begin
				wdg_fire = 1'b1;
			end else begin
				next_wdg_cnt = wdg_cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hv_fail_q <= 1'b0;
			dr_en <= 1'b0;
			wdg_cnt <= '1;
		end else begin
			hv_fail_q <= next_hv_fail;
			dr_en <= next_dr_en;
			wdg_cnt <= next_wdg_cnt;
		end
	end
	assign ee_hv_fail = hv_fail_q;
	assign ee_double_read_en = dr_en;

	// response: reset wins; sensors always feed either path, no mask exists
	fmr_state_e state, next_state;
	fmr_cause_t next_rst_cause, next_exc_cause, rst_cause_q, exc_cause_q;
	logic exc_q, next_exc;
	logic sens_rst, sens_exc, want_rst, want_exc;
	fmr_cause_t rst_code, exc_code;
	always_comb begin
		sens_rst = |(alarm_s2 & sensor_reset_sel);
		sens_exc = |(alarm_s2 & ~sensor_reset_sel);
		want_rst = sens_rst || par_rd_err || par_scan_err || wdg_fire;
		want_exc = sens_exc || stack_fault || (inverse_ecc_en && ecc_s2);
		if (sens_rst) begin
			rst_code = `FMR_CAUSE_SENSOR;
		end else if (par_rd_err) begin
			rst_code = `FMR_CAUSE_PARITY_RD;
		end else if (par_scan_err) begin
			rst_code = `FMR_CAUSE_PARITY_SCAN;
		end else begin
			rst_code = `FMR_CAUSE_WATCHDOG;
		end
		if (sens_exc) begin
			exc_code = `FMR_EXC_SENSOR;
		end else if (stack_fault) begin
			exc_code = `FMR_EXC_STACK;
		end else begin
			exc_code = `FMR_EXC_ECC;
		end
		next_state = state;
		next_rst_cause = rst_cause_q;
		next_exc_cause = exc_cause_q;
		next_exc = exc_q;
		case (state)
			FMR_RUN: begin
				if (exc_ack) begin
					next_exc = 1'b0;
				end
				if (want_rst) begin
					next_state = FMR_RESET;
					next_rst_cause = rst_code;
					next_exc = 1'b0;
					next_exc_cause = `FMR_EXC_NONE;
				end else if (want_exc) begin
					next_exc = 1'b1;
					next_exc_cause = exc_code;
				end
			end
			FMR_RESET: begin
				next_state = FMR_HOLD;
			end
			FMR_HOLD: begin
				// held while the alarm source persists
				if (!want_rst) begin
					next_state = FMR_RUN;
				end
			end
			default: begin
				next_state = FMR_RUN;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= FMR_RUN;
			rst_cause_q <= `FMR_CAUSE_POWERON;
			exc_cause_q <= `FMR_EXC_NONE;
			exc_q <= 1'b0;
		end else begin
			state <= next_state;
			rst_cause_q <= next_rst_cause;
			exc_cause_q <= next_exc_cause;
			exc_q <= next_exc;
		end
	end
	assign security_reset = (state != FMR_RUN);
	assign reset_cause = rst_cause_q;
	assign exception = exc_q;
	assign exc_cause = exc_cause_q;
endmodule

// File: fmr_top_properties.sv
// timing relations of the fault monitor and response unit
`timescale 1ns/1ps
`include "fmr_cfg.svh"
module fmr_top_properties #(
	parameter int SPW = `FMR_SP_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] sensor_alarm,
	input wire logic [3:0] sensor_reset_sel,
	input wire logic ram_req,
	input wire logic ram_we,
	input wire logic ram_rvalid,
	input wire logic [1:0] priv_level,
	input wire logic [`FMR_NLVL-1:0] sp_we,
	input wire logic [SPW-1:0] sp_wdata,
	input wire logic [`FMR_NLVL*SPW-1:0] sp_lim_hi,
	input wire logic [SPW-1:0] sp_active,
	input wire logic ee_ecc_err,
	input wire logic inverse_ecc_en,
	input wire logic double_read_set,
	input wire logic double_read_clr,
	input wire logic ee_double_read_en,
	input wire logic security_reset,
	input wire logic [3:0] reset_cause,
	input wire logic exception,
	input wire logic [3:0] exc_cause,
	input wire logic exc_ack
);
	// one clock domain, so clock and disable are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// a new reset may arrive mid-run, so values are checked at the first sampled high
	chk_reset_vals: assert property ($rose(rst_n) |-> reset_cause == 4'h8 && !exception && !security_reset)
		else $error("reset values wrong");
	chk_sensor_reset: assert property ($rose(sensor_alarm[0]) && sensor_reset_sel[0] |-> ##[2:5] security_reset && reset_cause == 4'h1)
		else $error("sensor reset missing");
	chk_sensor_exc: assert property ($rose(sensor_alarm[1]) && !sensor_reset_sel[1] && !sensor_alarm[0] |-> ##[2:5] exception && exc_cause == 4'h1)
		else $error("sensor exception missing");
	chk_exc_hold: assert property (exception && !exc_ack && !security_reset |=> exception || security_reset)
		else $error("exception dropped early");
	chk_reset_wins: assert property ($rose(security_reset) |=> !exception)
		else $error("exception beside reset");
	chk_reset_min: assert property ($rose(security_reset) |=> security_reset)
		else $error("reset too short");
	chk_read_ans: assert property (ram_rvalid == $past(ram_req && !ram_we))
		else $error("read answer late");
	chk_sp_copy: assert property (priv_level != 2'h3 && sp_we[priv_level] |=> sp_active == $past(sp_wdata))
		else $error("stack copy wrong");
	chk_stack_exc: assert property (priv_level != 2'h3 && sp_we[priv_level] && sp_wdata > sp_lim_hi[priv_level*SPW+:SPW]
		|-> ##[1:4] exception && exc_cause == 4'h2)
		else $error("stack exception missing");
	chk_ecc_exc: assert property (inverse_ecc_en && $rose(ee_ecc_err) |-> ##[2:5] exception && exc_cause == 4'h3)
		else $error("ecc exception missing");
	chk_dr_set: assert property (double_read_set && !double_read_clr |=> ee_double_read_en)
		else $error("double read not set");
	// main scenarios
	cover property (security_reset && reset_cause == 4'h4);
	cover property (exception && exc_cause == 4'h2);
	cover property ($rose(ram_rvalid));
endmodule

// File: testbench.sv
// self-checking bench for the fault monitor and response unit
`timescale 1ns/1ps
module testbench;
	import fmr_pkg::*;
	logic clk, rst_n, ram_req, ram_we, ram_rvalid, ee_write_active, ee_hv_ok, ee_hv_fail, ee_hv_clear, ee_ecc_err;
	logic inverse_ecc_en, double_read_set, double_read_clr, ee_double_read_en, wdg_enable, wdg_kick;
	logic security_reset, exception, exc_ack;
	logic [3:0] sensor_alarm, sensor_reset_sel, reset_cause, exc_cause;
	logic [5:0] ram_addr;
	logic [7:0] ram_wdata, ram_rdata;
	logic [1:0] priv_level;
	logic [2:0] sp_we;
	logic [15:0] sp_wdata, sp_active, wdg_reload;
	logic [47:0] sp_lim_lo, sp_lim_hi;
	int err_count = 0;
	int samples_checked = 0;
	fmr_top dut (
		.clk(clk), .rst_n(rst_n), .sensor_alarm(sensor_alarm), .sensor_reset_sel(sensor_reset_sel),
		.ram_req(ram_req), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.ram_rdata(ram_rdata), .ram_rvalid(ram_rvalid), .priv_level(priv_level), .sp_we(sp_we),
		.sp_wdata(sp_wdata), .sp_lim_lo(sp_lim_lo), .sp_lim_hi(sp_lim_hi), .sp_active(sp_active),
		.ee_write_active(ee_write_active), .ee_hv_ok(ee_hv_ok), .ee_hv_fail(ee_hv_fail),
		.ee_hv_clear(ee_hv_clear), .ee_ecc_err(ee_ecc_err), .inverse_ecc_en(inverse_ecc_en),
		.double_read_set(double_read_set), .double_read_clr(double_read_clr),
		.ee_double_read_en(ee_double_read_en), .wdg_enable(wdg_enable), .wdg_reload(wdg_reload),
		.wdg_kick(wdg_kick), .security_reset(security_reset), .reset_cause(reset_cause),
		.exception(exception), .exc_cause(exc_cause), .exc_ack(exc_ack)
	);
	// free running core clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run;
		$display("mismatches %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// bounded wait: 0 reset, 1 exception, 2 high voltage flag
	task automatic waitf(input int which, input logic lvl);
		int n;
		for (n = 0; n < 100; n++) begin
			@(negedge clk);
			if ((which == 0 ? security_reset : which == 1 ? exception : ee_hv_fail) === lvl)
				return;
		end
		chk("wait", 16'hdead, lvl);
		complete_run();
	endtask
	task automatic ram_op(input logic we, input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		{ram_req, ram_we, ram_addr, ram_wdata} <= {1'b1, we, a, d};
		@(posedge clk);
		ram_req <= 1'b0;
		@(negedge clk);
		if (!we) begin
			chk("rvalid", ram_rvalid, 1);
			chk("rdata", ram_rdata, d);
		end
	endtask
	// pulse one strobe: 0 ack, 1 hv clear, 2 dr set, 3 dr clr, 4 kick
	task automatic pulse(input int k);
		@(posedge clk);
		{wdg_kick, double_read_clr, double_read_set, ee_hv_clear, exc_ack} <= 5'h1 << k;
		@(posedge clk);
		{wdg_kick, double_read_clr, double_read_set, ee_hv_clear, exc_ack} <= 5'h0;
		repeat (2) @(negedge clk);
	endtask
	task automatic sp_wr(input int g, input logic [15:0] v);
		@(posedge clk);
		{priv_level, sp_we, sp_wdata} <= {2'(g), 3'(1 << g), v};
		@(posedge clk);
		sp_we <= 3'h0;
		repeat (3) @(negedge clk);
	endtask
	// whole ram written first so the scans during the long wait meet known parity
	task automatic t_ram;
		for (int i = 0; i < 64; i++)
			ram_op(1'b1, 6'(i), 8'(i * 7) ^ 8'ha5);
		repeat (300) @(negedge clk);
		chk("scan", security_reset, 0);
		chk("scan cause", reset_cause, 4'h8);
		ram_op(1'b0, 6'h00, 8'ha5);
		ram_op(1'b0, 6'h3f, 8'(63 * 7) ^ 8'ha5);
	endtask
	task automatic t_sensor;
		@(posedge clk);
		sensor_reset_sel <= 4'hf;
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			sensor_alarm <= 4'(1 << s);
			waitf(0, 1);
			chk("sensor cause", reset_cause, 4'h1);
			@(posedge clk);
			sensor_alarm <= 4'h0;
			waitf(0, 0);
		end
		@(posedge clk);
		{sensor_reset_sel, sensor_alarm} <= 8'h12;
		waitf(1, 1);
		chk("sensor exc", exc_cause, 4'h1);
		@(posedge clk);
		sensor_alarm <= 4'h0;
		// let the synchroniser drain, else the alarm re-raises beside the ack
		repeat (3) @(posedge clk);
		pulse(0);
		chk("acked", exception, 0);
		@(posedge clk);
		sensor_alarm <= 4'h3;
		waitf(0, 1);
		@(posedge clk);
		sensor_alarm <= 4'h0;
		waitf(0, 0);
		repeat (4) @(negedge clk);
		chk("dropped exc", exception, 0);
	endtask
	task automatic t_stack;
		for (int g = 0; g < 3; g++) begin
			sp_wr(g, 16'h0150 + 16'(g));
			chk("sp", sp_active, 16'h0150 + 16'(g));
			chk("sp in range", exception, 0);
			sp_wr(g, 16'h0201);
			waitf(1, 1);
			chk("stack cause", exc_cause, 4'h2);
			sp_wr(g, 16'h0150 + 16'(g));
			pulse(0);
		end
		@(posedge clk);
		priv_level <= 2'h0;
		repeat (3) @(negedge clk);
		chk("sp kept", sp_active, 16'h0150);
		@(posedge clk);
		priv_level <= 2'h3;
		repeat (2) @(negedge clk);
		chk("sp level3", sp_active, 16'h0152);
		@(posedge clk);
		sp_lim_lo <= 48'h0100;
		sp_wr(0, 16'h00ff);
		waitf(1, 1);
		chk("stack low cause", exc_cause, 4'h2);
		sp_wr(0, 16'h0150);
		pulse(0);
		chk("stack low acked", exception, 0);
	endtask
	task automatic t_ee;
		@(posedge clk);
		{ee_write_active, ee_hv_ok} <= 2'h2;
		waitf(2, 1);
		@(posedge clk);
		{ee_write_active, ee_hv_ok} <= 2'h1;
		repeat (8) @(negedge clk);
		chk("hv sticky", ee_hv_fail, 1);
		chk("hv no event", {exception, security_reset}, 0);
		pulse(1);
		chk("hv clear", ee_hv_fail, 0);
		@(posedge clk);
		ee_ecc_err <= 1'b1;
		repeat (8) @(negedge clk);
		chk("ecc quiet", exception, 0);
		@(posedge clk);
		ee_ecc_err <= 1'b0;
		repeat (4) @(posedge clk);
		{inverse_ecc_en, ee_ecc_err} <= 2'h3;
		waitf(1, 1);
		chk("ecc cause", exc_cause, 4'h3);
		@(posedge clk);
		ee_ecc_err <= 1'b0;
		repeat (3) @(posedge clk);
		pulse(0);
		chk("ecc acked", exception, 0);
		pulse(2);
		chk("dr set", ee_double_read_en, 1);
		pulse(3);
		chk("dr clr", ee_double_read_en, 0);
	endtask
	initial begin
		{rst_n, ram_req, ram_we, ram_addr, ram_wdata, ee_write_active, ee_hv_clear, ee_ecc_err, inverse_ecc_en} = '0;
		{double_read_set, double_read_clr, wdg_enable, wdg_kick, exc_ack, sensor_alarm, sensor_reset_sel} = '0;
		{priv_level, sp_we, sp_wdata, sp_lim_lo} = '0;
		ee_hv_ok = 1'b1;
		sp_lim_hi = {3{16'h0200}};
		wdg_reload = 16'h0008;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("cause", reset_cause, 4'h8);
		chk("flags", {security_reset, exception, ee_hv_fail, ee_double_read_en, exc_cause, sp_active}, 0);
		t_ram();
		t_sensor();
		t_stack();
		t_ee();
		@(posedge clk);
		wdg_enable <= 1'b1;
		pulse(4);
		waitf(0, 1);
		chk("wdg cause", reset_cause, 4'h4);
		@(posedge clk);
		wdg_enable <= 1'b0;
		waitf(0, 0);
		complete_run();
	end
endmodule
bind fmr_top fmr_top_properties #(.SPW(SPW)) chk_i (
	.clk(clk), .rst_n(rst_n), .sensor_alarm(sensor_alarm), .sensor_reset_sel(sensor_reset_sel),
	.ram_req(ram_req), .ram_we(ram_we), .ram_rvalid(ram_rvalid), .priv_level(priv_level),
	.sp_we(sp_we), .sp_wdata(sp_wdata), .sp_lim_hi(sp_lim_hi), .sp_active(sp_active),
	.ee_ecc_err(ee_ecc_err), .inverse_ecc_en(inverse_ecc_en), .double_read_set(double_read_set),
	.double_read_clr(double_read_clr), .ee_double_read_en(ee_double_read_en),
	.security_reset(security_reset), .reset_cause(reset_cause), .exception(exception),
	.exc_cause(exc_cause), .exc_ack(exc_ack)
);
